// ### rtl/fsr_top.sv
// status, configuration and id readout of a serial quad flash
`timescale 1ns/1ps
module fsr_top
  import fsr_pkg::*;
#(
  parameter int STATUS_WRITE_CMD_CYCLES  = 16,
  parameter int PROG_CYCLES  = 32,
  parameter int ERASE_CYCLES = 64
) (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       ce_i,
  input  wire logic       sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic       qpi_mode_i,
  input  wire logic [3:0] io_i,
  output logic      [3:0] io_o,
  output logic      [3:0] io_oe_n_o,
  output logic            busy_o,
  output logic            quad_enable_o,
  output logic      [2:0] drive_strength_o
);
  import fsr_pkg::*;

  initial begin
    if (STATUS_WRITE_CMD_CYCLES < 1 || STATUS_WRITE_CMD_CYCLES > 65535) $error("bad STATUS_WRITE_CMD_CYCLES");
    if (PROG_CYCLES < 1 || PROG_CYCLES > 65535) $error("bad PROG_CYCLES");
    if (ERASE_CYCLES < 1 || ERASE_CYCLES > 65535) $error("bad ERASE_CYCLES");
  end

  logic        rst_n;
  logic        frame_rst;
  logic        cs_s;
  logic        cs_prev;
  logic        wp_n_s;
  logic        frame_end;
  logic [16:0] link_sync;
  logic        q_s;
  fsr_status_t st;
  fsr_status_t st_s;
  fsr_config_t cf;
  fsr_config_t cf_s;
  fsr_frame_t  frm;
  fsr_rd_t     rd_kind;
  fsr_op_t     op;
  logic [15:0] op_cnt;
  logic [5:0]  cnt;
  logic [5:0]  next_cnt;
  logic [5:0]  step;
  logic [23:0] next_sr;
  logic [23:0] stream;
  logic [4:0]  out_pos;
  logic [4:0]  out_idx;
  logic        busy_q;
  logic        wel_q;
  logic [3:0]  bp_q;
  logic        qe_q;
  logic        status_write_disable_q;
  logic [2:0]  ods_q;
  logic        tb_q;
  logic [7:0]  wr_d0;
  logic [7:0]  wr_d1;
  logic        wr_cfg;
  logic        hardware_protect_state;
  logic        is_pe;
  logic        prot;
  logic        ev_write_enable_cmd;
  logic        ev_status_write_cmd;
  logic        ev_pe_try;
  logic        ev_ce_try;
  logic        blocked;
  logic        op_done;
  logic [15:0] busy_run;

  // reset release through two flops
  fsr_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_rst_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .ce_i   (1'b1),
    .d_i    (1'b1),
    .q_o    (rst_n)
  );

  fsr_sync #(.WIDTH(2), .RESET_VAL(2'b11)) u_pin_sync (
    .clk_i  (clk_i),
    .rstn_i (rst_n),
    .ce_i   (ce_i),
    .d_i    ({cs_n_i, io_i[2]}),
    .q_o    ({cs_s, wp_n_s})
  );

  // register bytes handed to the serial side; the copy is refreshed only
  // while deselected and during the command phase, so a byte never changes while shifted out
  fsr_sync #(.WIDTH(17), .RESET_VAL(17'h00007)) u_link_sync (
    .clk_i  (sclk_i),
    .rstn_i (rst_n),
    .ce_i   (cnt < CMD_BITS),
    .d_i    ({qpi_mode_i, st, cf}),
    .q_o    (link_sync)
  );

  assign q_s  = link_sync[16];
  assign st_s = link_sync[15:8];
  assign cf_s = link_sync[7:0];

  assign st = '{status_write_disable: status_write_disable_q, qe: qe_q, bp: bp_q, write_enable_latch: wel_q, busy: busy_q};
  assign cf = '{rsv: 4'h0, tb: tb_q, ods: ods_q};

  assign busy_o           = busy_q;
  assign quad_enable_o    = qe_q;
  assign drive_strength_o = ods_q;

  // serial side: chip select high ends the frame without a clock edge
  assign frame_rst = cs_n_i | ~rst_n;

  always_comb begin
    step = q_s ? STEP_QUAD : STEP_SINGLE;
    next_cnt = (cnt > CNT_MAX - step) ? CNT_MAX : cnt + step;
    // upper lines ignored outside quad mode
    next_sr = q_s ? {frm.sr[19:0], io_i} : {frm.sr[22:0], io_i[0]};
  end

  always_ff @(posedge sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      cnt     <= 6'h00;
      rd_kind <= RD_NONE;
    end else begin
      cnt <= next_cnt;
      if (cnt < CMD_BITS && next_cnt >= CMD_BITS) begin
        case (next_sr[7:0])
          CMD_STATUS_READ:  rd_kind <= RD_STATUS;
          CMD_CONFIG_READ:  rd_kind <= RD_CONFIG;
          CMD_QUAD_ID_READ: rd_kind <= q_s ? RD_ID : RD_NONE;
          default:          rd_kind <= RD_NONE;
        endcase
      end
    end
  end

  // frame record survives deselect so the system side can read it
  always_ff @(posedge sclk_i or negedge rst_n) begin
    if (!rst_n) begin
      frm <= '0;
    end else if (!cs_n_i) begin
      frm.sr  <= next_sr;
      frm.cnt <= next_cnt;
      if (cnt < CMD_BITS && next_cnt >= CMD_BITS) frm.cmd <= next_sr[7:0];
      if (cnt < ADDR_END && next_cnt >= ADDR_END) frm.addr <= next_sr;
    end
  end

  always_comb begin
    case (rd_kind)
      RD_STATUS: stream = {st_s, st_s, st_s};
      RD_CONFIG: stream = {cf_s, cf_s, cf_s};
      RD_ID:     stream = {ID_MANUFACTURER, ID_MEMORY_TYPE, ID_DENSITY};
      default:   stream = 24'h000000;
    endcase
    out_idx = OUT_MSB - out_pos;
  end

  // falling-edge shifter, wraps so bytes repeat until deselect
  always_ff @(negedge sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      out_pos   <= 5'h00;
      io_o      <= 4'h0;
      io_oe_n_o <= 4'hF;
    end else if (rd_kind != RD_NONE) begin
      if (q_s) begin
        io_oe_n_o <= 4'h0;
        io_o      <= stream[out_idx -: 4];
      end else begin
        io_oe_n_o <= 4'hD;
        io_o      <= {2'b00, stream[out_idx], 1'b0};
      end
      if (out_pos + step[4:0] >= OUT_WRAP) out_pos <= 5'h00;
      else out_pos <= out_pos + step[4:0];
    end
  end

  // system side: act once per frame, after deselect is seen
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) cs_prev <= 1'b1;
    else if (ce_i) cs_prev <= cs_s;
  end

  assign frame_end = cs_s & ~cs_prev;

  always_comb begin
    hardware_protect_state   = status_write_disable_q & ~wp_n_s & ~qe_q;
    is_pe = frm.cmd == CMD_PAGE_PROGRAM || frm.cmd == CMD_SECTOR_ERASE ||
            frm.cmd == CMD_HALF_BLK_ERS || frm.cmd == CMD_BLOCK_ERASE;
    prot  = fsr_protected(frm.addr, bp_q, tb_q);
    ev_write_enable_cmd = frame_end && frm.cnt >= CMD_BITS &&
              frm.cmd == CMD_WRITE_ENABLE && op == OP_IDLE;
    ev_status_write_cmd = frame_end && frm.cmd == CMD_STATUS_WRITE && wel_q &&
              (frm.cnt == STATUS_WRITE_CMD_ONE_BYTE || frm.cnt == STATUS_WRITE_CMD_TWO_BYTE) &&
              op == OP_IDLE && !hardware_protect_state;
    ev_pe_try = frame_end && is_pe && frm.cnt >= ADDR_END &&
                wel_q && op == OP_IDLE;
    ev_ce_try = frame_end && frm.cmd == CMD_CHIP_ERASE &&
                frm.cnt >= CMD_BITS && wel_q && op == OP_IDLE;
    blocked = (ev_pe_try && prot) ||
              (ev_ce_try && bp_q != 4'h0);
    op_done = op != OP_IDLE && op_cnt == 16'h0000;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      op     <= OP_IDLE;
      op_cnt <= 16'h0000;
    end else if (ce_i) begin
      case (op)
        OP_IDLE: begin
          if (ev_status_write_cmd) begin
            op     <= OP_STATUS_WRITE_CMD;
            op_cnt <= 16'(STATUS_WRITE_CMD_CYCLES - 1);
          end else if (ev_pe_try && !prot) begin
            op     <= (frm.cmd == CMD_PAGE_PROGRAM) ? OP_PROG : OP_ERASE;
            op_cnt <= (frm.cmd == CMD_PAGE_PROGRAM) ?
                      16'(PROG_CYCLES - 1) : 16'(ERASE_CYCLES - 1);
          end else if (ev_ce_try && bp_q == 4'h0) begin
            op     <= OP_ERASE;
            op_cnt <= 16'(ERASE_CYCLES - 1);
          end
        end
        OP_STATUS_WRITE_CMD, OP_PROG, OP_ERASE: begin
          if (op_done) op <= OP_IDLE;
          else op_cnt <= op_cnt - 16'h0001;
        end
        default: op <= OP_IDLE;
      endcase
    end
  end

  // busy follows the engine; the written data never reaches it
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) busy_q <= 1'b0;
    else if (ce_i) begin
      if (ev_status_write_cmd || (ev_pe_try && !prot) ||
          (ev_ce_try && bp_q == 4'h0)) busy_q <= 1'b1;
      else if (op_done) busy_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) wel_q <= 1'b0;
    else if (ce_i) begin
      if (ev_write_enable_cmd) wel_q <= 1'b1;
      else if (blocked) wel_q <= 1'b0;
      else if (op_done) wel_q <= 1'b0;
    end
  end

  // data is held and applied at the end of the write cycle
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_d0  <= 8'h00;
      wr_d1  <= 8'h00;
      wr_cfg <= 1'b0;
    end else if (ce_i && ev_status_write_cmd) begin
      wr_cfg <= frm.cnt == STATUS_WRITE_CMD_TWO_BYTE;
      wr_d0  <= (frm.cnt == STATUS_WRITE_CMD_TWO_BYTE) ? frm.sr[15:8] : frm.sr[7:0];
      wr_d1  <= frm.sr[7:0];
    end
  end

  // non-volatile fields are flops here: they restart at their defaults
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bp_q   <= BP_RESET;
      qe_q   <= QE_RESET;
      status_write_disable_q <= STATUS_WRITE_DISABLE_RESET;
      ods_q  <= ODS_RESET;
      tb_q   <= TB_RESET;
    end else if (ce_i && op == OP_STATUS_WRITE_CMD && op_done) begin
      bp_q   <= wr_d0[5:2];
      qe_q   <= wr_d0[6];
      status_write_disable_q <= wr_d0[7];
      if (wr_cfg) begin
        ods_q <= wr_d1[2:0];
        tb_q  <= tb_q | wr_d1[3];
      end
    end
  end

  // helper for the busy length check
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) busy_run <= 16'h0000;
    else if (ce_i) busy_run <= busy_q ? busy_run + 16'h0001 : 16'h0000;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_op_done;
    ce_i && op_done;
  endsequence

  sequence s_status_write_cmd_start;
    ce_i && ev_status_write_cmd;
  endsequence

  sequence s_status_write_cmd_running;
    busy_q && wel_q && op == OP_STATUS_WRITE_CMD;
  endsequence

  property p_busy_bounded;
    busy_run <= 16'(ERASE_CYCLES + PROG_CYCLES + STATUS_WRITE_CMD_CYCLES);
  endproperty
  a_busy_bounded: assert property (p_busy_bounded)
    else $error("busy held too long");

  property p_wel_clear_on_done;
    s_op_done |=> !wel_q && !busy_q;
  endproperty
  a_wel_clear_on_done: assert property (p_wel_clear_on_done)
    else $error("write latch or busy left set after operation");

  property p_pe_needs_wel;
    (ce_i && frame_end && is_pe && !wel_q && op == OP_IDLE) |=> !busy_q;
  endproperty
  a_pe_needs_wel: assert property (p_pe_needs_wel)
    else $error("program started without write latch");

  property p_protect_discard;
    (ce_i && blocked) |=> !wel_q && !busy_q && op == OP_IDLE;
  endproperty
  a_protect_discard: assert property (p_protect_discard)
    else $error("protected operation not discarded");

  property p_ce_refused;
    (ce_i && ev_ce_try && bp_q != 4'h0) |=> !busy_q;
  endproperty
  a_ce_refused: assert property (p_ce_refused)
    else $error("chip erase ran with protection set");

  property p_hpm_lock;
    (ce_i && hardware_protect_state && op == OP_IDLE) |=> op != OP_STATUS_WRITE_CMD;
  endproperty
  a_hpm_lock: assert property (p_hpm_lock)
    else $error("status write taken while locked");

  property p_status_write_cmd_flow;
    s_status_write_cmd_start |=> s_status_write_cmd_running ##1 busy_q;
  endproperty
  a_status_write_cmd_flow: assert property (p_status_write_cmd_flow)
    else $error("status write cycle not running");

  property p_tb_otp;
    $past(tb_q) |-> tb_q;
  endproperty
  a_tb_otp: assert property (p_tb_otp)
    else $error("top/bottom select cleared");

  property p_id_first_bit;
    @(negedge sclk_i) disable iff (frame_rst)
    (rd_kind == RD_ID && out_pos == 5'h00 && q_s) |->
      ##1 (io_o == ID_MANUFACTURER[7:4] && io_oe_n_o == 4'h0);
  endproperty
  a_id_first_bit: assert property (p_id_first_bit)
    else $error("id readout does not start with manufacturer");

endmodule : fsr_top

// ### rtl/fsr_pkg.sv
// shared constants, types and helpers of the flash status block
package fsr_pkg;

  // command codes (only the quad id code is fixed, the rest are defaults)
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
  localparam logic [7:0] CMD_STATUS_READ  = 8'h05;
  localparam logic [7:0] CMD_CONFIG_READ  = 8'h15;
  localparam logic [7:0] CMD_QUAD_ID_READ = 8'hAF;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] CMD_HALF_BLK_ERS = 8'h52;
  localparam logic [7:0] CMD_BLOCK_ERASE  = 8'hD8;
  localparam logic [7:0] CMD_CHIP_ERASE   = 8'h60;

  // identity bytes, values are arbitrary
  localparam logic [7:0] ID_MANUFACTURER  = 8'h5A;
  localparam logic [7:0] ID_MEMORY_TYPE   = 8'h11;
  localparam logic [7:0] ID_DENSITY       = 8'h22;

  // frame bit counts
  localparam logic [5:0] CNT_MAX          = 6'h3F;
  localparam logic [5:0] CMD_BITS         = 6'h08;
  localparam logic [5:0] STATUS_WRITE_CMD_ONE_BYTE    = 6'h10;
  localparam logic [5:0] STATUS_WRITE_CMD_TWO_BYTE    = 6'h18;
  localparam logic [5:0] ADDR_END         = 6'h20;
  localparam logic [5:0] STEP_SINGLE      = 6'h01;
  localparam logic [5:0] STEP_QUAD        = 6'h04;
  localparam logic [4:0] OUT_WRAP         = 5'h18;
  localparam logic [4:0] OUT_MSB          = 5'h17;

  // reset values of the register fields
  localparam logic [3:0] BP_RESET         = 4'h0;
  localparam logic       QE_RESET         = 1'b0;
  localparam logic       STATUS_WRITE_DISABLE_RESET       = 1'b0;
  localparam logic [2:0] ODS_RESET        = 3'h7;
  localparam logic       TB_RESET         = 1'b0;

  // protection span: 64 KB blocks out of 256
  localparam logic [8:0] BLK_ALL          = 9'h100;
  localparam logic [3:0] LVL_ALL          = 4'h9;

  typedef struct packed {
    logic       status_write_disable;
    logic       qe;
    logic [3:0] bp;
    logic       write_enable_latch;
    logic       busy;
  } fsr_status_t;

  typedef struct packed {
    logic [3:0] rsv;
    logic       tb;
    logic [2:0] ods;
  } fsr_config_t;

  typedef struct packed {
    logic [7:0]  cmd;
    logic [23:0] sr;
    logic [23:0] addr;
    logic [5:0]  cnt;
  } fsr_frame_t;

  typedef enum logic [1:0] {
    RD_NONE   = 2'b00,
    RD_STATUS = 2'b01,
    RD_CONFIG = 2'b10,
    RD_ID     = 2'b11
  } fsr_rd_t;

  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_STATUS_WRITE_CMD  = 2'b01,
    OP_PROG  = 2'b10,
    OP_ERASE = 2'b11
  } fsr_op_t;

  function automatic logic fsr_protected(input logic [23:0] a,
                                         input logic [3:0]  lvl,
                                         input logic        tb);
    logic [8:0] span;
    logic [8:0] blk;
    blk = {1'b0, a[23:16]};
    if (lvl == 4'h0) span = 9'h000;
    else if (lvl >= LVL_ALL) span = BLK_ALL;
    else span = 9'h001 << (lvl - 4'h1);
    if (tb) return blk < span;
    return blk >= (BLK_ALL - span);
  endfunction : fsr_protected

endpackage : fsr_pkg

// ### rtl/fsr_sync.sv
// two flip-flop level synchroniser with enable
`timescale 1ns/1ps
module fsr_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  initial begin
    if (WIDTH < 1) $error("fsr_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= RESET_VAL;
      q_o  <= RESET_VAL;
    end else if (ce_i) begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule : fsr_sync

// ### test/fsr_host_model.sv
// host controller model driving the serial link of the flash block
`timescale 1ns/1ps
module fsr_host_model (
  input  wire logic [3:0] dev_io_i,
  input  wire logic [3:0] dev_oe_n_i,
  output logic            sclk_o,
  output logic            cs_n_o,
  output logic            qpi_o,
  output logic      [3:0] io_o
);
  logic [3:0] drv;
  logic       wp_n;

  // lines the device does not drive carry host bits: frame data, wp_n on line 2 in single mode, else a toggling pattern
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      io_o[b] = dev_oe_n_i[b] ? drv[b] : dev_io_i[b];
    end
  end

  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    qpi_o  = 1'b0;
    drv    = 4'hA;
    wp_n   = 1'b1;
  end

  // one frame: ntx bits sent msb first, then nrx bits read back
  task automatic frame(input logic q, input logic [31:0] tx,
                       input int ntx, input int nrx,
                       output logic [31:0] rx);
    logic [31:0] sh;
    int          i;
    sh = tx;
    rx = 32'h0;
    if (q !== qpi_o) begin
      qpi_o = q;
      // deselected clock pulses let the new mode settle in the link domain
      repeat (2) begin
        #3 sclk_o = 1'b1;
        #3 sclk_o = 1'b0;
      end
      #3;
    end
    cs_n_o = 1'b0;
    for (i = 0; i < ntx + nrx; i += (q ? 4 : 1)) begin
      if (q && i < ntx) drv = sh[31:28];
      else if (q) drv = ~drv;
      else drv = {~drv[3], wp_n, ~drv[1], (i < ntx) ? sh[31] : ~drv[0]};
      #3 sclk_o = 1'b1;
      if (i >= ntx) rx = q ? {rx[27:0], io_o} : {rx[30:0], io_o[1]};
      sh = q ? sh << 4 : sh << 1;
      #3 sclk_o = 1'b0;
    end
    #3 cs_n_o = 1'b1;
    drv[2] = wp_n;
    // deselect time long enough for the system side to latch the frame
    #200;
  endtask : frame
endmodule : fsr_host_model

// ### test/fsr_top_tb.sv
// self-checking bench of the flash status, config and id block
`timescale 1ns/1ps
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin \
  miscompares++; $display("ERROR %s expected %h seen %h", what, exp, got); \
  end end
module fsr_top_tb;
  import fsr_pkg::*;
  localparam logic [31:0] EXP_ID = {ID_MANUFACTURER, ID_MEMORY_TYPE,
                                    ID_DENSITY, ID_MANUFACTURER};
  logic        clk_i;
  logic        rstn_i;
  logic        sclk;
  logic        cs_n;
  logic        qpi;
  logic  [3:0] io_line;
  logic  [3:0] io_out;
  logic  [3:0] io_oe_n;
  logic        busy;
  logic        qe_pin;
  logic  [2:0] ods_pin;
  int          checks;
  int          miscompares;
  logic        m_status_write_disable, m_qe, m_wel, m_bsy, m_tb;
  logic  [3:0] m_bp;
  logic  [2:0] m_ods;
  logic  [7:0] p_st;
  logic  [3:0] p_cfg;
  int          p_kind;
  logic  [7:0] v;
  logic [31:0] rx;
  logic  [3:0] lvl;
  logic  [2:0] ods;
  logic [23:0] a;
  logic  [7:0] ops [4] = '{CMD_PAGE_PROGRAM, CMD_SECTOR_ERASE,
                           CMD_HALF_BLK_ERS, CMD_BLOCK_ERASE};
  logic  [2:0] ods_ok [6] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  fsr_host_model host_u (.dev_io_i(io_out), .dev_oe_n_i(io_oe_n),
    .sclk_o(sclk), .cs_n_o(cs_n), .qpi_o(qpi), .io_o(io_line));

  fsr_top #(.STATUS_WRITE_CMD_CYCLES(40), .PROG_CYCLES(40), .ERASE_CYCLES(60)) dut_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .sclk_i(sclk),
    .cs_n_i(cs_n), .qpi_mode_i(qpi), .io_i(io_line), .io_o(io_out),
    .io_oe_n_o(io_oe_n), .busy_o(busy), .quad_enable_o(qe_pin),
    .drive_strength_o(ods_pin));

  function automatic logic [7:0] mstat();
    return {m_status_write_disable, m_qe, m_bp, m_wel, m_bsy};
  endfunction : mstat

  function automatic logic [7:0] mcfg();
    return {4'h0, m_tb, m_ods};
  endfunction : mcfg

  // level L from 1 to 9 covers 2^(L-1) of 256 blocks, level 0 none and above 9 all, top or bottom
  function automatic logic prot(input logic [23:0] ad);
    int span;
    span = (m_bp == 0) ? 0 : (m_bp >= 9) ? 256 : 1 << (m_bp - 1);
    return m_tb ? (ad[23:16] < span) : (ad[23:16] >= 256 - span);
  endfunction : prot

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  task automatic rd(input logic q, input logic [7:0] c,
                    output logic [7:0] r);
    logic [31:0] x;
    host_u.frame(q, {c, 24'h0}, 8, 16, x);
    `CHK("repeat", x[15:8], x[7:0])
    r = x[7:0];
  endtask : rd

  task automatic chk_st(input logic q);
    logic [7:0] s;
    rd(q, CMD_STATUS_READ, s);
    `CHK("status", mstat(), s)
  endtask : chk_st

  task automatic send(input logic [31:0] t, input int n);
    logic [31:0] x;
    host_u.frame(1'b0, t, n, 0, x);
  endtask : send

  task automatic write_enable_cmd();
    send({CMD_WRITE_ENABLE, 24'h0}, 8);
    if (!m_bsy) m_wel = 1'b1;
  endtask : write_enable_cmd

  task automatic status_write_cmd(input logic [7:0] s, input logic [3:0] c,
                      input int n);
    send({CMD_STATUS_WRITE, s, 4'h0, c, 8'h0}, n);
    // pin lock only while quad enable is off
    if (m_wel && !m_bsy && !(m_status_write_disable && !host_u.wp_n && !m_qe)) begin
      m_bsy  = 1'b1;
      p_st   = s;
      p_cfg  = c;
      p_kind = n;
    end
    `CHK("busy pin", m_bsy, busy)
  endtask : status_write_cmd

  task automatic op(input logic [7:0] c, input logic [23:0] ad);
    logic hit;
    hit = (c == CMD_CHIP_ERASE) ? (m_bp != 4'h0) : prot(ad);
    send({c, ad}, (c == CMD_CHIP_ERASE) ? 8 : 32);
    if (m_wel && !m_bsy && hit) m_wel = 1'b0;
    else if (m_wel && !m_bsy) begin
      m_bsy  = 1'b1;
      p_kind = 2;
    end
    `CHK("busy pin", m_bsy, busy)
  endtask : op

  task automatic wait_idle();
    logic [7:0] s;
    int         k;
    for (k = 0; k < 40; k++) begin
      rd(1'b0, CMD_STATUS_READ, s);
      if (s[0] === 1'b0) break;
    end
    if (k == 40) begin
      miscompares++;
      $display("ERROR busy poll expected 0 seen 1");
      wrap_up();
    end
    if (p_kind >= 16) {m_status_write_disable, m_qe, m_bp} = p_st[7:2];
    if (p_kind == 24) begin
      m_ods = p_cfg[2:0];
      m_tb  = m_tb | p_cfg[3];
    end
    if (p_kind != 0) m_wel = 1'b0;
    m_bsy  = 1'b0;
    p_kind = 0;
    `CHK("status", mstat(), s)
    `CHK("qe pin", m_qe, qe_pin)
    `CHK("drive pin", m_ods, ods_pin)
  endtask : wait_idle

  initial begin
    rstn_i = 1'b0;
    checks = 0;
    miscompares = 0;
    {m_status_write_disable, m_qe, m_wel, m_bsy, m_tb, m_bp} = '0;
    m_ods = 3'h7;
    p_kind = 0;
    void'($urandom(32'h5d45));
    repeat (8) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    repeat (6) @(posedge clk_i);
    `CHK("oe idle", 4'hF, io_oe_n)
    chk_st(1'b0);
    rd(1'b0, CMD_CONFIG_READ, v);
    `CHK("config", mcfg(), v)
    host_u.frame(1'b1, {CMD_QUAD_ID_READ, 24'h0}, 8, 32, rx);
    `CHK("id", EXP_ID, rx)
    chk_st(1'b1);
    rd(1'b1, CMD_CONFIG_READ, v);
    `CHK("config", mcfg(), v)
    $display("test reset_and_modes done");
    op(CMD_PAGE_PROGRAM, 24'h000100);
    lvl = 4'($urandom_range(8, 1));
    write_enable_cmd();
    status_write_cmd({2'b00, lvl, 2'b11}, 4'h0, 16);
    chk_st(1'b0);
    rd(1'b0, CMD_CONFIG_READ, v);
    `CHK("config busy", mcfg(), v)
    wait_idle();
    $display("test level_write done");
    for (int j = 0; j < 8; j++) begin
      a = {(j < 4) ? 8'hFF : 8'h00, 16'($urandom)};
      write_enable_cmd();
      op(ops[j % 4], a);
      chk_st(1'b0);
      wait_idle();
    end
    write_enable_cmd();
    op(CMD_CHIP_ERASE, 24'h0);
    ods = ods_ok[$urandom_range(5, 0)];
    write_enable_cmd();
    status_write_cmd(8'h00, {1'b1, ods}, 24);
    wait_idle();
    write_enable_cmd();
    op(CMD_CHIP_ERASE, 24'h0);
    wait_idle();
    write_enable_cmd();
    status_write_cmd(8'h00, 4'h7, 24);
    wait_idle();
    rd(1'b0, CMD_CONFIG_READ, v);
    `CHK("config", mcfg(), v)
    $display("test erase_and_config done");
    write_enable_cmd();
    status_write_cmd(8'h80, 4'h0, 16);
    wait_idle();
    host_u.wp_n = 1'b0;
    write_enable_cmd();
    status_write_cmd(8'h3C, 4'h0, 16);
    chk_st(1'b0);
    host_u.wp_n = 1'b1;
    write_enable_cmd();
    status_write_cmd(8'hC0, 4'h0, 16);
    wait_idle();
    host_u.wp_n = 1'b0;
    write_enable_cmd();
    status_write_cmd(8'h00, 4'h0, 16);
    wait_idle();
    $display("test lock done");
    wrap_up();
  end
endmodule : fsr_top_tb
